// ==== hdl/asc_top.sv ====
// sequencing control for the ten bit converter
`default_nettype none
module asc_top
    import asc_pkg::*;
(
    input  wire logic       core_clk_in,
    input  wire logic       rst_in,
    input  wire logic [7:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic [7:0]      rdata_out,
    input  wire logic       global_irq_en_in,
    input  wire logic       vector_ack_in,
    input  wire logic [7:0] trig_sources_in,
    input  wire logic [9:0] sample_data_in,
    output logic            irq_out,
    output logic            conv_power_out,
    output logic            sample_out,
    output logic [3:0]      pos_ch_out,
    output logic [3:0]      neg_ch_out,
    output logic            diff_out
);
    asc_state_t state_q;
    logic [7:0] ctrl_q;
    logic [7:0] mux_q;
    logic [2:0] trig_sel_q;
    logic [4:0] active_sel_q;
    logic [9:0] result_q;
    logic       lock_q;
    logic       first_q;
    logic       trig_q;
    logic [5:0] cyc_q;
    logic [5:0] cyc_len_q;
    logic       tick;
    logic       trig_now;
    logic       trig_edge;
    logic       wr_ctrl;
    logic       start_req;
    logic       finish;
    logic       enable;
    logic       ladj;

    assign enable  = ctrl_q[ASC_BIT_ENABLE];
    assign ladj    = mux_q[ASC_BIT_LADJ];
    assign wr_ctrl = wr_in && (addr_in == ASC_ADDR_CTRL);

    // selected trigger, free running uses done flag
    always_comb begin
        if (trig_sel_q == ASC_TRIG_FREE) begin
            trig_now = ctrl_q[ASC_BIT_DONE]; // (R19)
        end else begin
            trig_now = trig_sources_in[trig_sel_q]; // (R19)
        end
    end
    assign trig_edge = ctrl_q[ASC_BIT_AUTO] && trig_now && !trig_q; // (R08)

    // start from software write or trigger edge
    assign start_req = (wr_ctrl && wdata_in[ASC_BIT_START] && wdata_in[ASC_BIT_ENABLE])
                     || (enable && trig_edge); // (R05)
    assign finish = (state_q == ASC_CONV) && tick && (cyc_q == cyc_len_q - 6'h01);

    asc_prescaler u_presc (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .run_in      (enable && state_q == ASC_CONV),
        .div_sel_in  (ctrl_q[2:0]),
        .tick_out    (tick)
    );

    asc_input_route u_route (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .sel_in      (active_sel_q),
        .pos_out     (pos_ch_out),
        .neg_out     (neg_ch_out),
        .diff_out    (diff_out)
    );

    // trigger level history for edge detection
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            trig_q <= 1'b0;
        end else begin
            trig_q <= trig_now;
        end
    end

    // conversion sequencer
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q   <= ASC_IDLE;
            cyc_q     <= 6'h00;
            cyc_len_q <= ASC_NORMAL_CYCLES;
            first_q   <= 1'b1;
        end else if (wr_ctrl && !wdata_in[ASC_BIT_ENABLE]) begin // (R04)
            state_q <= ASC_IDLE;
            cyc_q   <= 6'h00;
            first_q <= 1'b1;
        end else begin
            case (state_q)
                ASC_IDLE: begin
                    if (start_req) begin
                        state_q   <= ASC_CONV;
                        cyc_q     <= 6'h00; // (R21)
                        cyc_len_q <= first_q ? ASC_FIRST_CYCLES : ASC_NORMAL_CYCLES; // (R06)
                        first_q   <= 1'b0;
                    end
                end
                ASC_CONV: begin
                    if (finish) begin
                        cyc_q <= 6'h00;
                        // free running restarts at once
                        if (ctrl_q[ASC_BIT_AUTO] && trig_sel_q == ASC_TRIG_FREE) begin // (R05)
                            cyc_len_q <= ASC_NORMAL_CYCLES;
                        end else begin
                            state_q <= ASC_IDLE;
                        end
                    end else if (tick) begin
                        cyc_q <= cyc_q + 6'h01;
                    end
                end
                default: state_q <= ASC_IDLE;
            endcase
        end
    end

    // control register with start, done and enables
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_q <= ASC_CTRL_RESET; // (R18)
        end else begin
            if (wr_ctrl) begin
                ctrl_q[ASC_BIT_ENABLE] <= wdata_in[ASC_BIT_ENABLE]; // (R04)
                ctrl_q[ASC_BIT_AUTO]   <= wdata_in[ASC_BIT_AUTO];
                ctrl_q[ASC_BIT_IRQ_EN] <= wdata_in[ASC_BIT_IRQ_EN];
                ctrl_q[2:0]            <= wdata_in[2:0];
            end
            // start bit mirrors busy; zero write ignored
            ctrl_q[ASC_BIT_START] <= (wr_ctrl && !wdata_in[ASC_BIT_ENABLE]) ? 1'b0
                : (start_req || (state_q == ASC_CONV && !(finish
                   && !(ctrl_q[ASC_BIT_AUTO] && trig_sel_q == ASC_TRIG_FREE)))); // (R07)
            // set wins over clear
            if (finish && !lock_q) begin
                ctrl_q[ASC_BIT_DONE] <= 1'b1; // (R09)
            end else if (vector_ack_in || (wr_ctrl && wdata_in[ASC_BIT_DONE])) begin
                ctrl_q[ASC_BIT_DONE] <= 1'b0; // (R10)
            end
        end
    end

    // mux register and trigger source register
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            mux_q      <= ASC_MUX_RESET;
            trig_sel_q <= 3'h0;
        end else begin
            if (wr_in && addr_in == ASC_ADDR_MUX) begin
                mux_q <= wdata_in;
            end
            if (wr_in && addr_in == ASC_ADDR_CTRL_B) begin
                trig_sel_q <= wdata_in[2:0];
            end
        end
    end

    // selection latched only between conversions
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            active_sel_q <= 5'h00;
        end else if (state_q == ASC_IDLE && !start_req) begin
            active_sel_q <= mux_q[4:0]; // (R01)
        end else if (finish) begin
            active_sel_q <= mux_q[4:0]; // (R01)
        end
    end

    // result store and read lock
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            result_q <= 10'h000;
            lock_q   <= 1'b0;
        end else begin
            if (finish && !lock_q) begin
                result_q <= sample_data_in; // (R22)
            end
            if (rd_in && addr_in == ASC_ADDR_RES_LOW) begin
                lock_q <= 1'b1; // (R13)
            end else if (rd_in && addr_in == ASC_ADDR_RES_HIGH) begin
                lock_q <= 1'b0; // (R13)
            end
        end
    end

    // read data one cycle after strobe
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_out <= 8'h00;
        end else if (rd_in) begin
            case (addr_in)
                ASC_ADDR_RES_LOW: rdata_out <= ladj ? {result_q[1:0], 6'h00}
                                                     : result_q[7:0]; // (R14) (R15) (R20)
                ASC_ADDR_RES_HIGH: rdata_out <= ladj ? result_q[9:2]
                                                      : {6'h00, result_q[9:8]}; // (R14) (R15)
                ASC_ADDR_CTRL:   rdata_out <= ctrl_q;
                ASC_ADDR_CTRL_B: rdata_out <= {5'h00, trig_sel_q};
                ASC_ADDR_MUX:    rdata_out <= mux_q;
                default:         rdata_out <= 8'h00;
            endcase
        end else begin
            rdata_out <= 8'h00;
        end
    end

    // outputs to analog core and interrupt
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_out        <= 1'b0;
            conv_power_out <= 1'b0;
            sample_out     <= 1'b0;
        end else begin
            irq_out <= ctrl_q[ASC_BIT_DONE] && ctrl_q[ASC_BIT_IRQ_EN]
                       && global_irq_en_in; // (R11)
            conv_power_out <= enable; // (R04)
            // launch pulse for software, trigger and free-running restarts
            sample_out     <= (state_q == ASC_IDLE && start_req && !(wr_ctrl
                               && !wdata_in[ASC_BIT_ENABLE]))
                              || (finish && ctrl_q[ASC_BIT_AUTO]
                                  && trig_sel_q == ASC_TRIG_FREE
                                  && !(wr_ctrl && !wdata_in[ASC_BIT_ENABLE])); // (R05)
        end
    end

    a_lock_holds: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (lock_q && !(rd_in && addr_in == ASC_ADDR_RES_HIGH)) |=> $stable(result_q)) // (R13)
        else $error("result changed while locked");
    a_done_on_finish: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (finish && !lock_q) |=> ctrl_q[ASC_BIT_DONE] && result_q == $past(sample_data_in)) // (R09)
        else $error("done flag or result not loaded");
    a_disable_aborts: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (wr_ctrl && !wdata_in[ASC_BIT_ENABLE]) |=> state_q == ASC_IDLE
        && !ctrl_q[ASC_BIT_START]) // (R04)
        else $error("disable did not abort");
    a_start_busy: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (state_q == ASC_CONV && !finish && !(wr_ctrl && !wdata_in[ASC_BIT_ENABLE]))
        |=> ctrl_q[ASC_BIT_START]) // (R07)
        else $error("start bit low while busy");
    a_first_length: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (state_q == ASC_IDLE && start_req && first_q) |=> cyc_len_q == 6'h19) // (R06)
        else $error("first conversion length wrong");
    a_irq_follows: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (ctrl_q[ASC_BIT_DONE] && ctrl_q[ASC_BIT_IRQ_EN] && global_irq_en_in) |=> irq_out) // (R11)
        else $error("interrupt not raised");
    a_clear_by_one: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (wr_ctrl && wdata_in[ASC_BIT_DONE] && !finish) |=> !ctrl_q[ASC_BIT_DONE]) // (R10)
        else $error("done flag not cleared");
    a_sel_stable: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (state_q == ASC_CONV && !finish && $past(state_q) == ASC_CONV)
        |=> $stable(active_sel_q)) // (R01)
        else $error("selection changed mid conversion");
endmodule
`default_nettype wire

// ==== hdl/asc_pkg.sv ====
// constants and types for the converter sequencing control
// How it works
// (R01) new input selection waits for conversion end
// (R02) codes 0-7 single ended, 30 bandgap, 31 ground
// (R03) codes 16-29 differential against channel 1 or 2
// (R04) enable powers on; clearing aborts conversion
// (R05) start launches one, or first free-running
// (R06) first conversion 25 cycles, others 13
// (R07) start reads one while busy; zero ignored
// (R08) auto trigger starts on selected source edge
// (R09) done flag set when result is stored
// (R10) done clears on vector or written one
// (R11) interrupt while done, enable, global enable
// (R12) prescaler codes divide by 2 to 128
// (R13) low read locks result until high read
// (R14) right adjusted byte layout
// (R15) left adjusted byte layout
// (R16) software reads low byte before high byte
// (R17) software avoids read-modify-write of control
// (R18) control register at 0x7A resets to zero
// (R19) trigger source codes select eight sources
// (R20) left adjust changes presentation immediately
// (R21) prescaler runs only while enabled; counter restarts
// (R22) done flag and result load together unless locked
`default_nettype none
package asc_pkg;
    localparam logic [7:0] ASC_ADDR_RES_LOW  = 8'h78;
    localparam logic [7:0] ASC_ADDR_RES_HIGH = 8'h79;
    localparam logic [7:0] ASC_ADDR_CTRL     = 8'h7A;
    localparam logic [7:0] ASC_ADDR_CTRL_B   = 8'h7B;
    localparam logic [7:0] ASC_ADDR_MUX      = 8'h7C;
    localparam logic [7:0] ASC_CTRL_RESET    = 8'h00;
    localparam logic [7:0] ASC_MUX_RESET     = 8'h00;
    localparam int ASC_BIT_ENABLE  = 7;
    localparam int ASC_BIT_START   = 6;
    localparam int ASC_BIT_AUTO    = 5;
    localparam int ASC_BIT_DONE    = 4;
    localparam int ASC_BIT_IRQ_EN  = 3;
    localparam int ASC_BIT_LADJ    = 5;
    localparam logic [5:0] ASC_FIRST_CYCLES  = 6'h19; // 25 converter clocks
    localparam logic [5:0] ASC_NORMAL_CYCLES = 6'h0D; // 13 converter clocks
    localparam logic [2:0] ASC_TRIG_FREE     = 3'h0;
    localparam logic [4:0] ASC_SEL_BANDGAP   = 5'h1E;
    localparam logic [4:0] ASC_SEL_GROUND    = 5'h1F;
    localparam logic [3:0] ASC_CH_NONE       = 4'hF;
    typedef enum logic [1:0] {
        ASC_IDLE  = 2'b00,
        ASC_CONV  = 2'b01
    } asc_state_t;
endpackage
`default_nettype wire

// ==== hdl/asc_prescaler.sv ====
// prescaler producing a converter clock tick
`default_nettype none
module asc_prescaler
    import asc_pkg::*;
(
    input  wire logic       core_clk_in,
    input  wire logic       rst_in,
    input  wire logic       run_in,
    input  wire logic [2:0] div_sel_in,
    output logic            tick_out
);
    logic [6:0] cnt_q;
    logic [6:0] limit;

    // terminal count from divider code
    always_comb begin
        case (div_sel_in)
            3'h0, 3'h1: limit = 7'h01;
            3'h2:       limit = 7'h03;
            3'h3:       limit = 7'h07;
            3'h4:       limit = 7'h0F;
            3'h5:       limit = 7'h1F;
            3'h6:       limit = 7'h3F;
            default:    limit = 7'h7F;
        endcase
    end

    // count only while enabled
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_q    <= 7'h00;
            tick_out <= 1'b0;
        end else if (!run_in) begin // (R21)
            cnt_q    <= 7'h00;
            tick_out <= 1'b0;
        end else begin
            tick_out <= (cnt_q >= limit); // (R12)
            cnt_q    <= (cnt_q >= limit) ? 7'h00 : cnt_q + 7'h01;
        end
    end

    a_tick_spacing: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (tick_out && run_in && $stable(div_sel_in) && div_sel_in <= 3'h1)
        |-> ##1 !tick_out ##1 (tick_out || !$past(run_in) || $past(div_sel_in) > 3'h1)) // (R12)
        else $error("divide by two tick spacing wrong");
endmodule
`default_nettype wire

// ==== hdl/asc_input_route.sv ====
// decoder of input selection into positive and negative channels
`default_nettype none
module asc_input_route
    import asc_pkg::*;
(
    input  wire logic       core_clk_in,
    input  wire logic       rst_in,
    input  wire logic [4:0] sel_in,
    output logic [3:0]      pos_out,
    output logic [3:0]      neg_out,
    output logic            diff_out
);
    // registered route; 8 bandgap, 9 ground, F none
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pos_out  <= 4'h0;
            neg_out  <= ASC_CH_NONE;
            diff_out <= 1'b0;
        end else begin
            if (sel_in[4:3] == 2'b00) begin // (R02)
                pos_out  <= {1'b0, sel_in[2:0]};
                neg_out  <= ASC_CH_NONE;
                diff_out <= 1'b0;
            end else if (sel_in == ASC_SEL_BANDGAP) begin // (R02)
                pos_out  <= 4'h8;
                neg_out  <= ASC_CH_NONE;
                diff_out <= 1'b0;
            end else if (sel_in == ASC_SEL_GROUND) begin // (R02)
                pos_out  <= 4'h9;
                neg_out  <= ASC_CH_NONE;
                diff_out <= 1'b0;
            end else if (sel_in[4:3] == 2'b01) begin // (R02)
                pos_out  <= ASC_CH_NONE;
                neg_out  <= ASC_CH_NONE;
                diff_out <= 1'b0;
            end else begin // (R03)
                pos_out  <= {1'b0, sel_in[2:0]};
                neg_out  <= sel_in[3] ? 4'h2 : 4'h1;
                diff_out <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== sim/adc_sequencing_control_bench.sv ====
// self-checking bench for the converter sequencing control
`default_nettype none
module adc_sequencing_control_bench
    import asc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic       core_clk_in      = 1'b0;
    logic       rst_in           = 1'b1;
    logic [7:0] addr_in          = 8'h00;
    logic [7:0] wdata_in         = 8'h00;
    logic       wr_in            = 1'b0;
    logic       rd_in            = 1'b0;
    logic       global_irq_en_in = 1'b1;
    logic       vector_ack_in    = 1'b0;
    logic [7:0] trig_sources_in  = 8'h00;
    logic [9:0] sample_data_in   = 10'h000;
    logic [7:0] rdata_out;
    logic       irq_out;
    logic       conv_power_out;
    logic       sample_out;
    logic [3:0] pos_ch_out;
    logic [3:0] neg_ch_out;
    logic       diff_out;
    int         mismatches = 0;
    int         n_tests    = 0;
    int         samples    = 0;

    asc_top dut_u (
        .core_clk_in(core_clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .global_irq_en_in(global_irq_en_in), .vector_ack_in(vector_ack_in),
        .trig_sources_in(trig_sources_in), .sample_data_in(sample_data_in),
        .irq_out(irq_out), .conv_power_out(conv_power_out), .sample_out(sample_out),
        .pos_ch_out(pos_ch_out), .neg_ch_out(neg_ch_out), .diff_out(diff_out)
    );

    // 200 MHz clock
    always #2.5 core_clk_in = ~core_clk_in;

    // counts conversion launches seen at the analog side
    always @(posedge core_clk_in) begin
        if (sample_out === 1'b1) samples <= samples + 1;
    end

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // passes when n lies in the window, else reports the lower bound
    task automatic span(input string what, input int n, input int lo, input int hi);
        chk(what, (n >= lo && n <= hi) ? 16'(n) : 16'(lo), 16'(n));
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge core_clk_in);
        wr_in <= 1'b0;
    endtask

    // read data stand in the cycle after the strobe
    task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string what);
        @(posedge core_clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge core_clk_in);
        rd_in <= 1'b0;
        #1;
        chk(what, 16'(e), 16'(rdata_out));
    endtask

    task automatic wait_irq(output int n);
        n = 0;
        do begin
            @(posedge core_clk_in);
            #1;
            n++;
        end while (irq_out !== 1'b1 && n < 5000);
    endtask

    task automatic settle(input int k);
        repeat (k) @(posedge core_clk_in);
        #1;
    endtask

    // stops a hung run
    initial begin
        #(40000 * 5);
        mismatches++;
        report_and_stop();
    end

    // main sequence
    initial begin
        int          n;
        int          d;
        int          s0;
        logic [9:0]  r1;
        logic [9:0]  r2;
        logic [3:0]  ep;
        logic [3:0]  en;
        logic        ed;
        logic [7:0]  regs[6];
        void'($urandom(32'hE228));
        regs = '{ASC_ADDR_RES_LOW, ASC_ADDR_RES_HIGH, ASC_ADDR_CTRL, ASC_ADDR_CTRL_B,
                 ASC_ADDR_MUX, 8'h55};
        repeat (2) @(posedge core_clk_in);
        rst_in <= 1'b0;
        wr(ASC_ADDR_RES_LOW, 8'hFF);
        wr(8'h55, 8'hFF);
        foreach (regs[i]) rchk(regs[i], 8'h00, "reset value");
        // input routing for every selection code
        for (int c = 0; c < 32; c++) begin
            ep = 4'hF;
            en = 4'hF;
            ed = 1'b0;
            if (c < 8) ep = 4'(c);
            else if (c >= 16 && c < 24) begin
                ep = 4'(c - 16);
                en = 4'h1;
                ed = 1'b1;
            end else if (c >= 24 && c < 30) begin
                ep = 4'(c - 24);
                en = 4'h2;
                ed = 1'b1;
            end else if (c == 30) ep = 4'h8;
            else if (c == 31) ep = 4'h9;
            wr(ASC_ADDR_MUX, 8'(c));
            settle(2);
            chk("route", {7'h00, ed, ep, en}, {7'h00, diff_out, pos_ch_out, neg_ch_out});
        end
        // every prescaler code: first and follow-on conversion
        for (int c = 0; c < 8; c++) begin
            d  = (c < 2) ? 2 : (1 << c);
            r1 = 10'($urandom);
            r2 = 10'($urandom);
            sample_data_in <= r1;
            s0 = samples;
            wr(ASC_ADDR_MUX, 8'h00);
            wr(ASC_ADDR_CTRL, 8'hC8 | 8'(c));
            wait_irq(n);
            span("first length", n, 25 * d - 3, 26 * d + 3);
            chk("launches", 16'(s0 + 1), 16'(samples));
            chk("power", 16'h1, 16'(conv_power_out));
            rchk(ASC_ADDR_CTRL, 8'h98 | 8'(c), "ctrl done");
            rchk(ASC_ADDR_RES_LOW, r1[7:0], "low right");
            rchk(ASC_ADDR_RES_HIGH, {6'h00, r1[9:8]}, "high right");
            wr(ASC_ADDR_MUX, 8'h20);
            rchk(ASC_ADDR_RES_LOW, {r1[1:0], 6'h00}, "low left");
            rchk(ASC_ADDR_RES_HIGH, r1[9:2], "high left");
            global_irq_en_in <= 1'b0;
            settle(3);
            chk("irq masked", 16'h0, 16'(irq_out));
            global_irq_en_in <= 1'b1;
            settle(3);
            chk("irq raised", 16'h1, 16'(irq_out));
            sample_data_in <= r2;
            wr(ASC_ADDR_CTRL, 8'hD8 | 8'(c));
            wait_irq(n);
            span("next length", n, 13 * d - 3, 14 * d + 3);
            rchk(ASC_ADDR_RES_HIGH, r2[9:2], "high only");
            @(posedge core_clk_in);
            vector_ack_in <= 1'b1;
            @(posedge core_clk_in);
            vector_ack_in <= 1'b0;
            settle(3);
            chk("irq after vector", 16'h0, 16'(irq_out));
            rchk(ASC_ADDR_CTRL, 8'h88 | 8'(c), "ctrl cleared");
            wr(ASC_ADDR_CTRL, 8'h00);
            settle(2);
            chk("power off", 16'h0, 16'(conv_power_out));
        end
        // low read locks result, new selection waits for conversion end
        r1 = 10'($urandom);
        r2 = 10'($urandom);
        sample_data_in <= r1;
        wr(ASC_ADDR_MUX, 8'h00);
        wr(ASC_ADDR_CTRL, 8'hC8);
        wait_irq(n);
        rchk(ASC_ADDR_RES_LOW, r1[7:0], "locked low");
        sample_data_in <= r2;
        wr(ASC_ADDR_CTRL, 8'hD8);
        settle(60);
        chk("irq while locked", 16'h0, 16'(irq_out));
        rchk(ASC_ADDR_RES_HIGH, {6'h00, r1[9:8]}, "locked high");
        rchk(ASC_ADDR_CTRL, 8'h88, "ctrl locked");
        wr(ASC_ADDR_CTRL, 8'hC8);
        wr(ASC_ADDR_MUX, 8'h03);
        settle(1);
        chk("route held", 16'h0, 16'(pos_ch_out));
        rchk(ASC_ADDR_CTRL, 8'hC8, "ctrl busy");
        wait_irq(n);
        settle(3);
        chk("route applied", 16'h3, 16'(pos_ch_out));
        rchk(ASC_ADDR_RES_LOW, r2[7:0], "low new");
        rchk(ASC_ADDR_RES_HIGH, {6'h00, r2[9:8]}, "high new");
        // zero start write is ignored; disabling aborts
        wr(ASC_ADDR_CTRL, 8'h10);
        s0 = samples;
        wr(ASC_ADDR_CTRL, 8'h88);
        settle(40);
        chk("no launch", 16'(s0), 16'(samples));
        wr(ASC_ADDR_CTRL, 8'hC8);
        settle(10);
        wr(ASC_ADDR_CTRL, 8'h08);
        settle(80);
        rchk(ASC_ADDR_CTRL, 8'h08, "ctrl aborted");
        chk("irq aborted", 16'h0, 16'(irq_out));
        // free running: one start write, conversions follow
        wr(ASC_ADDR_CTRL_B, 8'h00);
        s0 = samples;
        wr(ASC_ADDR_CTRL, 8'hE0);
        settle(200);
        wr(ASC_ADDR_CTRL, 8'h10);
        span("free launches", samples - s0, 5, 8);
        // every external trigger source, edge only
        for (int src = 1; src < 8; src++) begin
            wr(ASC_ADDR_CTRL_B, 8'(src));
            wr(ASC_ADDR_CTRL, 8'hB0);
            s0 = samples;
            @(posedge core_clk_in);
            trig_sources_in <= ~(8'h01 << src) & 8'hFE;
            settle(5);
            chk("other source", 16'(s0), 16'(samples));
            trig_sources_in <= 8'hFF;
            settle(5);
            chk("trigger edge", 16'(s0 + 1), 16'(samples));
            settle(60);
            chk("trigger level", 16'(s0 + 1), 16'(samples));
            trig_sources_in <= 8'h00;
            settle(2);
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
